/* File: rtl/asram_pkg.sv */
// Package for the static memory host controller: geometry, pin encodings and timing counts.
// Assumes a 125 MHz system clock; all times are in nanoseconds.
package asram_pkg;
	localparam int ASRAM_ADDR_W = 18;
	localparam int ASRAM_DATA_W = 16;
	localparam int ASRAM_BYTE_W = 8;
	localparam int ASRAM_CLK_PERIOD_NS = 8;
	// Slowest speed grade figures, safe for every grade.
	localparam int ASRAM_READ_CYCLE_MIN_NS = 100;
	localparam int ASRAM_WRITE_CYCLE_MIN_NS = 100;
	localparam int ASRAM_WRITE_PULSE_MIN_NS = 70;
	localparam int ASRAM_ADDR_SETUP_NS = 0;
	localparam int ASRAM_WRITE_RECOVERY_NS = 0;
	localparam int ASRAM_OE_VALID_MAX_NS = 50;
	// Least times round up to whole cycles, never below one.
	function automatic int asram_cycles_up(input int ns);
		int c;
		c = (ns + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int ASRAM_READ_CYCLES = asram_cycles_up(ASRAM_READ_CYCLE_MIN_NS);
	localparam int ASRAM_WRITE_CYCLES = asram_cycles_up(ASRAM_WRITE_CYCLE_MIN_NS);
	localparam int ASRAM_WPULSE_CYCLES = asram_cycles_up(ASRAM_WRITE_PULSE_MIN_NS);
	localparam int ASRAM_SETUP_CYCLES = asram_cycles_up(ASRAM_ADDR_SETUP_NS);
	localparam int ASRAM_RECOV_CYCLES = asram_cycles_up(ASRAM_WRITE_RECOVERY_NS);
	localparam int ASRAM_CNT_W = 8;
	// Byte mask encodings on the user side: bit 0 low byte, bit 1 high byte.
	localparam logic [1:0] ASRAM_MASK_NONE = 2'h0;
	localparam logic [1:0] ASRAM_MASK_WORD = 2'h3;
	typedef enum logic [3:0] {
		ASRAM_IDLE = 4'h1,
		ASRAM_READ = 4'h2,
		ASRAM_WSETUP = 4'h4,
		ASRAM_WPULSE = 4'h8
	} asram_state_t;
endpackage

/* File: rtl/asram_timer.sv */
// Down counter that marks the end of a programmed interval.
// Assumes one clock; load and load value come from the owning state machine; the count runs down on its own.
`timescale 1ns/1ps
module asram_timer import asram_pkg::*; #(
	parameter int CNT_W = ASRAM_CNT_W
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [CNT_W-1:0] load_value,
	output logic done
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
	} asram_tmr_t;
	asram_tmr_t state_r;
	asram_tmr_t state_nxt;

	// Load wins over counting; the counter rests at zero.
	always_comb begin
		state_nxt = state_r;
		if (load) begin
			state_nxt.count = load_value;
		end else if (state_r.count != '0) begin
			state_nxt.count = state_r.count - 1'b1;
		end
	end

	// Synchronous reset to an expired timer.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Expiry depends only on the registered count.
	// The owner raises load from done, so done must not look at load or the two would form a loop.
	assign done = (state_r.count == '0);
endmodule // asram_timer

/* File: rtl/asram_host.sv */
// Host controller for an asynchronous 256K x 16 static memory with byte enables.
// Assumes one 125 MHz clock, synchronous pin inputs, and a board that resolves the data lanes from the enables.
`timescale 1ns/1ps
module asram_host import asram_pkg::*; #(
	parameter int READ_CYCLES = ASRAM_READ_CYCLES,
	parameter int WRITE_CYCLES = ASRAM_WRITE_CYCLES,
	parameter int WPULSE_CYCLES = ASRAM_WPULSE_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [ASRAM_ADDR_W-1:0] req_addr,
	input wire logic [1:0] req_mask,
	input wire logic [ASRAM_DATA_W-1:0] req_wdata,
	output logic rsp_valid,
	output logic [ASRAM_DATA_W-1:0] rsp_rdata,
	output logic [ASRAM_ADDR_W-1:0] word_addr,
	output logic chip_sel_n,
	output logic out_en_n,
	output logic write_en_n,
	output logic low_byte_en_n,
	output logic high_byte_en_n,
	input wire logic [ASRAM_DATA_W-1:0] data_lanes_in,
	output logic [ASRAM_DATA_W-1:0] data_lanes_out,
	output logic [1:0] data_lanes_oe
);
	// Elaboration checks: the write strobe must fall for at least one whole cycle.
	if (WPULSE_CYCLES < 1) begin : g_bad_pulse
		$error("asram_host: write pulse must last at least one cycle");
	end

	// The write cycle must hold set-up, pulse and recovery, or the tail count would wrap.
	if (WRITE_CYCLES < WPULSE_CYCLES + ASRAM_SETUP_CYCLES + ASRAM_RECOV_CYCLES) begin : g_bad_wcycle
		$error("asram_host: write cycle shorter than set-up, pulse and recovery");
	end

	// A read needs one cycle to open the lanes and one to sample them.
	if (READ_CYCLES < 2) begin : g_short_read
		$error("asram_host: read cycle must be at least two cycles");
	end

	// Every interval must fit the eight-bit interval timer.
	if (READ_CYCLES > 255) begin : g_long_read
		$error("asram_host: read cycle does not fit the timer");
	end

	// The write cycle is loaded in three parts (set-up, pulse, tail), but the whole must still fit the timer.
	if (WRITE_CYCLES > 255) begin : g_long_write
		$error("asram_host: write cycle does not fit the timer");
	end

	// The pulse is loaded on its own and must fit as well.
	if (WPULSE_CYCLES > 255) begin : g_long_pulse
		$error("asram_host: write pulse does not fit the timer");
	end

	typedef struct packed {
		asram_state_t st;
		logic [ASRAM_ADDR_W-1:0] addr;
		logic [ASRAM_DATA_W-1:0] wdata;
		logic [1:0] mask;
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic [1:0] drive;
		logic rsp;
		logic [ASRAM_DATA_W-1:0] rdata;
		logic [ASRAM_CNT_W-1:0] rest;
	} asram_host_t;
	asram_host_t state_r;
	asram_host_t state_nxt;
	logic tmr_load;
	logic [ASRAM_CNT_W-1:0] tmr_value;
	logic tmr_done;

	// Interval timer for the read cycle, write set-up, write pulse and write cycle tail.
	asram_timer #(.CNT_W(ASRAM_CNT_W)) u_timer (
		.clock(clock),
		.reset_n(reset_n),
		.load(tmr_load),
		.load_value(tmr_value),
		.done(tmr_done)
	);

	// Byte mask to active-low enable pair; unused mask bits stay high.
	function automatic logic [1:0] asram_lane_en_n(input logic [1:0] mask);
		return ~mask;
	endfunction

	// Sequencer for one access at a time.
	// A read opens select and output enable on the edge that takes the request,
	// waits out the whole read cycle and samples the lanes on its last cycle.
	// A write opens select with the address and the lanes one cycle before the
	// write strobe falls, holds the strobe for the pulse time, raises strobe and
	// select together and then keeps address and data for the rest of the cycle.
	// Keeping data past the strobe's rise gives hold time without a second edge.
	// The timer's done flag is level, so a state that loads on done does so once.
	always_comb begin
		state_nxt = state_r;
		state_nxt.rsp = 1'b0;
		tmr_load = 1'b0;
		tmr_value = '0;
		unique case (state_r.st)
			ASRAM_IDLE: begin
				state_nxt.cs_n = 1'b1;
				state_nxt.oe_n = 1'b1;
				state_nxt.we_n = 1'b1;
				state_nxt.drive = 2'b00;
				// An empty mask would be a null access, so it is answered at once.
				if (req_valid && req_mask == ASRAM_MASK_NONE) begin
					state_nxt.rsp = 1'b1;
					state_nxt.rdata = '0;
				end else if (req_valid) begin
					state_nxt.addr = req_addr;
					state_nxt.mask = req_mask;
					state_nxt.wdata = req_wdata;
					state_nxt.cs_n = 1'b0;
					tmr_load = 1'b1;
					if (req_write) begin
						// Address and lanes settle one cycle before write enable falls.
						state_nxt.st = ASRAM_WSETUP;
						state_nxt.drive = req_mask;
						tmr_value = ASRAM_CNT_W'(ASRAM_SETUP_CYCLES - 1);
					end else begin
						state_nxt.st = ASRAM_READ;
						state_nxt.oe_n = 1'b0;
						tmr_value = ASRAM_CNT_W'(READ_CYCLES - 1);
					end
				end
			end
			ASRAM_READ: begin
				// Sample the lanes at the end of the read cycle, well after output valid.
				if (tmr_done) begin
					state_nxt.rdata[ASRAM_BYTE_W-1:0] = state_r.mask[0] ? data_lanes_in[ASRAM_BYTE_W-1:0] : '0;
					state_nxt.rdata[ASRAM_DATA_W-1:ASRAM_BYTE_W] =
						state_r.mask[1] ? data_lanes_in[ASRAM_DATA_W-1:ASRAM_BYTE_W] : '0;
					state_nxt.rsp = 1'b1;
					state_nxt.cs_n = 1'b1;
					state_nxt.oe_n = 1'b1;
					state_nxt.st = ASRAM_IDLE;
				end
			end
			ASRAM_WSETUP: begin
				// Set-up over: drop the write strobe and split the cycle into pulse and tail.
				if (tmr_done) begin
					state_nxt.we_n = 1'b0;
					tmr_load = 1'b1;
					tmr_value = ASRAM_CNT_W'(WPULSE_CYCLES - 1);
					state_nxt.rest = ASRAM_CNT_W'(WRITE_CYCLES - WPULSE_CYCLES - ASRAM_SETUP_CYCLES);
					state_nxt.st = ASRAM_WPULSE;
				end
			end
			ASRAM_WPULSE: begin
				// First expiry ends the pulse; the second ends the write cycle tail.
				if (!state_r.we_n && tmr_done) begin
					// Write enable and chip select rise together; lanes and address hold past the edge.
					state_nxt.we_n = 1'b1;
					state_nxt.cs_n = 1'b1;
					tmr_load = 1'b1;
					tmr_value = ASRAM_CNT_W'(state_r.rest - 1'b1);
				end else if (state_r.we_n && tmr_done) begin
					state_nxt.drive = 2'b00;
					state_nxt.rsp = 1'b1;
					state_nxt.st = ASRAM_IDLE;
				end
			end
			// An illegal code can only come from an upset; recover to idle.
			default: begin
				state_nxt.st = ASRAM_IDLE;
			end
		endcase
	end

	// Synchronous reset leaves the memory deselected and all lanes released.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_r <= '{st: ASRAM_IDLE, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
		end else begin
			state_r <= state_nxt;
		end
	end

	// Pin and user outputs from the state flip-flops; byte enables gated by chip select.
	assign req_ready = (state_r.st == ASRAM_IDLE);
	assign rsp_valid = state_r.rsp;
	assign rsp_rdata = state_r.rdata;
	assign word_addr = state_r.addr;
	assign chip_sel_n = state_r.cs_n;
	assign out_en_n = state_r.oe_n;
	assign write_en_n = state_r.we_n;
	assign {high_byte_en_n, low_byte_en_n} = (state_r.cs_n) ? 2'b11 : asram_lane_en_n(state_r.mask);
	assign data_lanes_out = state_r.wdata;
	assign data_lanes_oe = state_r.drive;
endmodule // asram_host

/* File: tb/asram_host_chk.sv */
// Assertions on the host controller's memory pins and response timing.
// Assumes it is bound to the controller and sees its ports only.
`timescale 1ns/1ps
module asram_host_chk import asram_pkg::*; #(
	parameter int WPULSE_CYCLES = ASRAM_WPULSE_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic [1:0] req_mask,
	input wire logic rsp_valid,
	input wire logic [ASRAM_ADDR_W-1:0] word_addr,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	input wire logic low_byte_en_n,
	input wire logic high_byte_en_n,
	input wire logic [ASRAM_DATA_W-1:0] data_lanes_out,
	input wire logic [1:0] data_lanes_oe
);
	logic [7:0] wlow_r;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Counts the cycles the write strobe has been low.
	always_ff @(posedge clock) begin
		wlow_r <= (!reset_n || write_en_n) ? 8'h00 : wlow_r + 8'h01;
	end
	a_reset_idle: assert property ($rose(reset_n) |-> chip_sel_n && write_en_n && out_en_n && !data_lanes_oe && req_ready)
		else $error("controller not idle after reset");
	a_deselect_quiet: assert property (chip_sel_n |-> low_byte_en_n && high_byte_en_n && write_en_n && out_en_n)
		else $error("strobes active while deselected");
	a_write_overlap: assert property (!write_en_n |-> !chip_sel_n && out_en_n && data_lanes_oe != 2'h0)
		else $error("write strobe outside a selected write");
	a_pulse_width: assert property ($rose(write_en_n) |-> wlow_r == WPULSE_CYCLES)
		else $error("write pulse length wrong");
	a_write_end: assert property ($rose(write_en_n) |-> $rose(chip_sel_n))
		else $error("write end not with select release");
	a_addr_steady: assert property (!write_en_n |-> $stable(word_addr) && $stable(data_lanes_out))
		else $error("address or data moved in write pulse");
	a_no_contend: assert property (!out_en_n |-> data_lanes_oe == 2'h0 && write_en_n && !chip_sel_n)
		else $error("lanes driven during read");
	a_byte_enables: assert property (req_valid && req_ready && req_mask != 2'h0
		|-> ##2 {high_byte_en_n, low_byte_en_n} == ~$past(req_mask, 2))
		else $error("byte enables differ from mask");
	a_read_time: assert property (req_valid && req_ready && !req_write && req_mask != 2'h0
		|-> ##1 !rsp_valid[*8] ##[4:6] rsp_valid)
		else $error("read answer timing wrong");
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
	c_low_write: cover property (!write_en_n && !low_byte_en_n && high_byte_en_n);
	c_high_read: cover property (!out_en_n && low_byte_en_n && !high_byte_en_n);
	c_empty_mask: cover property (req_valid && req_ready && req_mask == ASRAM_MASK_NONE);
endmodule // asram_host_chk
bind asram_host asram_host_chk #(.WPULSE_CYCLES(WPULSE_CYCLES)) u_chk (.*);

/* File: tb/asram_mem_model.sv */
// Behavioural static memory standing on the far side of the controller.
// Assumes the bench resolves the shared lanes from both parties' enables.
`timescale 1ns/1ps
module asram_mem_model import asram_pkg::*; (
	input wire logic clock,
	input wire logic [ASRAM_ADDR_W-1:0] word_addr,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	input wire logic low_byte_en_n,
	input wire logic high_byte_en_n,
	input wire logic [ASRAM_DATA_W-1:0] lanes,
	output logic [ASRAM_DATA_W-1:0] rd_data,
	output logic [1:0] rd_en
);
	logic [ASRAM_DATA_W-1:0] mem [int];
	// Drives only enabled lanes in a selected read; lanes float otherwise.
	always_comb begin
		rd_en = (!chip_sel_n && !out_en_n && write_en_n) ? ~{high_byte_en_n, low_byte_en_n} : 2'h0;
		rd_data = mem.exists(int'(word_addr)) ? mem[int'(word_addr)] : 16'hxxxx;
	end
	// Stores the enabled bytes while select and write strobe overlap.
	always @(posedge clock) begin
		if (!chip_sel_n && !write_en_n) begin
			if (!mem.exists(int'(word_addr))) mem[int'(word_addr)] = 16'hxxxx;
			if (!low_byte_en_n) mem[int'(word_addr)][7:0] = lanes[7:0];
			if (!high_byte_en_n) mem[int'(word_addr)][15:8] = lanes[15:8];
		end
	end
endmodule // asram_mem_model

/* File: tb/testbench.sv */
// Self-checking bench: controller against the behavioural memory.
// Assumes default timing parameters and a board that resolves the lanes.
`timescale 1ns/1ps
module testbench import asram_pkg::*;;
	logic clock = 0, reset_n = 0, req_valid = 0, req_ready, req_write = 0, rsp_valid;
	logic chip_sel_n, out_en_n, write_en_n, low_byte_en_n, high_byte_en_n;
	logic [1:0] req_mask = 0, data_lanes_oe, rd_en;
	logic [17:0] req_addr = 0, word_addr;
	logic [15:0] req_wdata = 0, rsp_rdata, data_lanes_in, data_lanes_out, rd_data, flt = 16'h5a5a, q;
	int error_cnt = 0, n_tests = 0, n;
	asram_host u_dut (.*);
	asram_mem_model u_mem (.lanes(data_lanes_in), .*);
	// A released lane shows a pattern that changes every cycle.
	always #4 clock = ~clock;
	always @(posedge clock) flt <= ~flt;
	assign data_lanes_in[7:0] = data_lanes_oe[0] ? data_lanes_out[7:0] : rd_en[0] ? rd_data[7:0] : flt[7:0];
	assign data_lanes_in[15:8] = data_lanes_oe[1] ? data_lanes_out[15:8] : rd_en[1] ? rd_data[15:8] : flt[15:8];
	task automatic chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("tests %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Issues one request and waits, bounded, for its answer.
	task automatic op(input logic wr, input logic [17:0] a, input logic [1:0] m, input logic [15:0] d);
		req_valid = 1;
		req_write = wr;
		req_addr = a;
		req_mask = m;
		req_wdata = d;
		@(posedge clock);
		#1 req_valid = 0;
		n = 1;
		while (rsp_valid !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1 n++;
		end
		q = rsp_rdata;
	endtask
	task automatic t_reset();
		chk("idle strobes", {chip_sel_n, write_en_n, out_en_n, req_ready}, 18'hf);
		chk("lanes released", data_lanes_oe, 0);
		$display("test reset done");
	endtask
	task automatic t_word();
		op(1, 18'h3ffff, ASRAM_MASK_WORD, 16'ha5c3);
		chk("write done", rsp_valid, 1);
		op(0, 18'h3ffff, ASRAM_MASK_WORD, 0);
		chk("word read", q, 16'ha5c3);
		chk("read latency", n >= 13 && n <= 15, 1);
		$display("test word done");
	endtask
	task automatic t_bytes();
		op(1, 18'h1, ASRAM_MASK_WORD, 16'h1234);
		op(1, 18'h1, 2'h1, 16'h9956);
		op(0, 18'h1, ASRAM_MASK_WORD, 0);
		chk("low byte write", q, 16'h1256);
		op(1, 18'h1, 2'h2, 16'hab77);
		op(0, 18'h1, 2'h1, 0);
		chk("low byte read", q, 16'h0056);
		op(0, 18'h1, 2'h2, 0);
		chk("high byte read", q, 16'hab00);
		$display("test bytes done");
	endtask
	task automatic t_edge();
		op(0, 18'h2, ASRAM_MASK_WORD, 0);
		chk("unwritten read", q, 16'hxxxx);
		op(1, 18'h2, ASRAM_MASK_NONE, 16'hffff);
		chk("empty mask answer", n, 1);
		chk("empty mask pins", {chip_sel_n, write_en_n}, 18'h3);
		$display("test edge done");
	endtask
	initial begin
		repeat (2000) @(posedge clock);
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge clock);
		#1 reset_n = 1;
		@(posedge clock);
		#1 t_reset();
		t_word();
		t_bytes();
		t_edge();
		complete_run();
	end
endmodule // testbench
